// ---- design/atb_cfg.svh ----
`ifndef ATB_CFG_SVH
`define ATB_CFG_SVH
// Overview of operation
// - mode 000 without mode1 clocks prescaler from kernel
// - counter enable starts prescaler division
// - modes 1,2,3,7 use trigger source
// - mode 7 counts channel pin edges
// - mode 7 sources 0-3: trigger rising
// - external trigger selected by mode1 or 7/7
// - one pulse per synchronised trigger rise
// - division factors 1 through 65536
// - prescaler write applies at next update
// - up mode wraps to 0, overflow
// - up update after repetition+1 overflows
// - software update in up clears counter
// - update disable suppresses update events
// - update loads repetition, reload, prescaler shadows
// - down mode reloads at 0, underflow
// - down update after repetition+1 underflows
// - software update in down loads reload
// - center mode alternates, events at reload-1, 1
// - center mode direction bit read-only
// - software update in center clears counter
// - center mode flag on both events
// - sixteen bit counter and prescaler

// ==========================================
// register offsets
`define ATB_OFS_CTL 8'h00
`define ATB_OFS_SMCFG 8'h04
`define ATB_OFS_SWEVG 8'h08
`define ATB_OFS_INTF 8'h0c
`define ATB_OFS_CNT 8'h10
`define ATB_OFS_PSC 8'h14
`define ATB_OFS_CAR 8'h18
`define ATB_OFS_REPETITION_COUNT 8'h1c
`define ATB_OFS_CTL2 8'h20
// ==========================================
// control field positions
`define ATB_CTL_CEN 0
`define ATB_CTL_UPDATE_DISABLE 1
`define ATB_CTL_DIR 4
`define ATB_CTL_CAM_LO 5
`define ATB_SMC_LO 0
`define ATB_EXT_CLOCK_MODE1_ENABLE_BIT 3
`define ATB_TRIGGER_SOURCE_SELECT_LO 4
// ==========================================
// reset values
`define ATB_RST_CAR 16'hffff
`define ATB_RST_PSC 16'h0000
`define ATB_RST_REPETITION_COUNT 8'h00
`endif

// ---- design/atb_pkg.sv ----
package atb_pkg;
  typedef enum logic [2:0] {
    ATB_SM_INTERNAL = 3'b000,
    ATB_SM_EXT0 = 3'b111
  } atb_smc_t;
  typedef enum logic [1:0] {
    ATB_CAM_EDGE = 2'b00,
    ATB_CAM_CENTER1 = 2'b01,
    ATB_CAM_CENTER2 = 2'b10,
    ATB_CAM_CENTER3 = 2'b11
  } atb_cam_t;
  typedef enum logic [1:0] {
    ATB_PAIR_INDEP = 2'b00,
    ATB_PAIR_MIRROR = 2'b01,
    ATB_PAIR_RSVD = 2'b10,
    ATB_PAIR_COMPL = 2'b11
  } atb_pair_t;
endpackage : atb_pkg

// ---- design/atb_time_base.sv ----
`timescale 1ns/100ps
`include "atb_cfg.svh"
module atb_time_base #(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] internal_trigger_input,
  input wire logic external_trigger_input,
  input wire logic [3:0] main_channel_in,
  input wire logic [3:0] partner_channel_in,
  input wire logic [3:0] main_channel_oc,
  input wire logic [3:0] partner_channel_oc,
  output logic [3:0] main_channel_out,
  output logic [3:0] partner_channel_out,
  output logic [3:0] partner_capture_en,
  output logic [CNT_W-1:0] count_value,
  output logic overflow_pulse,
  output logic underflow_pulse,
  output logic update_pulse,
  output logic count_dir
);
  // ==========================================
  // elaboration checks
  if (CNT_W != 16) begin : g_bad_w
    $error("counter width must be 16");
  end
  if (REP_W < 1 || REP_W > 16) begin : g_bad_rep
    $error("repetition width out of range");
  end

  // ==========================================
  // registers
  logic cen_r;
  logic update_disable_r;
  logic dir_r;
  logic [1:0] cam_r;
  logic [2:0] smc_r;
  logic ext_clock_mode1_enable_r;
  logic [3:0] trigger_source_select_r;
  logic [7:0] pair_mode_r;
  logic [CNT_W-1:0] psc_pre_r;
  logic [CNT_W-1:0] psc_sh_r;
  logic [CNT_W-1:0] car_pre_r;
  logic [CNT_W-1:0] car_sh_r;
  logic [REP_W-1:0] rep_pre_r;
  logic [REP_W-1:0] rep_sh_r;
  logic [REP_W-1:0] rep_cnt_r;
  logic [CNT_W-1:0] psc_cnt_r;
  logic [CNT_W-1:0] cnt_r;
  logic uif_r;

  // ==========================================
  // input synchronisers and edge detection
  logic [12:0] sync1_r;
  logic [12:0] sync2_r;
  logic [12:0] sync3_r;
  wire [12:0] pins_in = {external_trigger_input, partner_channel_in, main_channel_in, internal_trigger_input};
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_r <= 13'h0000;
      sync2_r <= 13'h0000;
      sync3_r <= 13'h0000;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  wire [12:0] rise = sync2_r & ~sync3_r;
  wire [12:0] fall = ~sync2_r & sync3_r;
  wire [12:0] both_edge = rise | fall;

  // ==========================================
  // prescaler input clock select
  wire trigger_source_select_iti = (trigger_source_select_r <= 4'h3);
  wire [1:0] iti_idx = trigger_source_select_r[1:0];
  wire iti_tick = rise[iti_idx];
  // 4..6 main pins 0..2 any edge, 8..b main 0..3, c..d partner 0..1
  wire [3:0] pin_sel = trigger_source_select_r - 4'h4;
  wire pin_lo = (trigger_source_select_r >= 4'h4) && (trigger_source_select_r <= 4'h6);
  wire pin_hi = (trigger_source_select_r >= 4'h8) && (trigger_source_select_r <= 4'hd);
  wire [3:0] hi_sel = trigger_source_select_r - 4'h8;
  wire pin_tick = (pin_lo && both_edge[4 + pin_sel[1:0]]) ||
                  (pin_hi && both_edge[4 + hi_sel[2:0]]);
  wire eti_sel = ext_clock_mode1_enable_r || (smc_r == atb_pkg::ATB_SM_EXT0 && trigger_source_select_r == 4'h7);
  wire eti_tick = rise[12];
  wire trg_src = (smc_r == 3'h1) || (smc_r == 3'h2) || (smc_r == 3'h3) ||
                 (smc_r == atb_pkg::ATB_SM_EXT0);
  wire src_tick = trigger_source_select_iti ? iti_tick : pin_tick;
  wire timer_tick = eti_sel ? eti_tick : (trg_src ? src_tick : 1'b1);
  wire prescaler_input_clock = cen_r && timer_tick;

  // ==========================================
  // prescaler: factor is value plus one
  wire psc_wrap = (psc_cnt_r >= psc_sh_r);
  wire counting_clock = prescaler_input_clock && psc_wrap;

  // ==========================================
  // counter events
  wire center = (cam_r != atb_pkg::ATB_CAM_EDGE);
  // direction bit is software's in edge modes, hardware's in center modes
  wire up_dir = ~dir_r;
  wire at_top = (cnt_r >= car_sh_r);
  wire at_zero = (cnt_r == 16'h0000);
  wire [CNT_W-1:0] car_m1 = car_sh_r - 16'h0001;
  wire [CNT_W-1:0] cnt_inc = cnt_r + 16'h0001;
  wire [CNT_W-1:0] cnt_dec = cnt_r - 16'h0001;
  // center events fire as the count steps onto reload-1 and onto 1
  wire ovf_center = up_dir && (cnt_inc == car_m1);
  wire udf_center = !up_dir && (cnt_r == 16'h0002);
  wire ovf_edge = up_dir && at_top;
  wire udf_edge = !up_dir && at_zero;
  wire ovf = counting_clock && (center ? ovf_center : ovf_edge);
  wire udf = counting_clock && (center ? udf_center : udf_edge);
  wire wr_swevg = reg_wr && (reg_addr == `ATB_OFS_SWEVG);
  wire swu = wr_swevg && reg_wdata[0];
  wire rep_done = (rep_cnt_r == {REP_W{1'b0}});
  wire upd_hw = (ovf || udf) && rep_done;
  wire upd = (upd_hw || swu) && !update_disable_r;

  // ==========================================
  // counter next value
  wire [CNT_W-1:0] swu_load = (!center && dir_r) ? car_sh_r : 16'h0000;
  wire [CNT_W-1:0] up_nxt = at_top ? (center ? cnt_dec : 16'h0000) : cnt_inc;
  wire [CNT_W-1:0] dn_nxt = at_zero ? (center ? 16'h0001 : car_sh_r) : cnt_dec;
  wire [CNT_W-1:0] step_nxt = up_dir ? up_nxt : dn_nxt;
  wire [CNT_W-1:0] cnt_nxt;
  assign cnt_nxt = swu ? swu_load : (counting_clock ? step_nxt : cnt_r);
  // turn one step early so the count never leaves 0..reload
  wire turn_down = up_dir && (cnt_r >= car_m1);
  wire turn_up = !up_dir && (cnt_r <= 16'h0001);
  wire dir_flip = center && counting_clock && (turn_down || turn_up);

  // ==========================================
  // register writes
  wire wr_ctl = reg_wr && (reg_addr == `ATB_OFS_CTL);
  wire wr_smcfg = reg_wr && (reg_addr == `ATB_OFS_SMCFG);
  wire wr_psc = reg_wr && (reg_addr == `ATB_OFS_PSC);
  wire wr_car = reg_wr && (reg_addr == `ATB_OFS_CAR);
  wire wr_repetition_count = reg_wr && (reg_addr == `ATB_OFS_REPETITION_COUNT);
  wire wr_ctl2 = reg_wr && (reg_addr == `ATB_OFS_CTL2);
  wire [1:0] cam_wdata = reg_wdata[`ATB_CTL_CAM_LO +: 2];
  // the mode being written decides whether software owns the direction
  wire dir_wr_ok = (cam_wdata == atb_pkg::ATB_CAM_EDGE);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cen_r <= 1'b0;
      update_disable_r <= 1'b0;
      cam_r <= 2'b00;
    end else if (wr_ctl) begin
      cen_r <= reg_wdata[`ATB_CTL_CEN];
      update_disable_r <= reg_wdata[`ATB_CTL_UPDATE_DISABLE];
      cam_r <= cam_wdata;
    end
  end

  // center mode: software update restarts upward
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dir_r <= 1'b0;
    end else if (wr_ctl && dir_wr_ok) begin
      dir_r <= reg_wdata[`ATB_CTL_DIR];
    end else if (swu && center) begin
      dir_r <= 1'b0;
    end else if (dir_flip) begin
      dir_r <= ~dir_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      smc_r <= 3'b000;
      ext_clock_mode1_enable_r <= 1'b0;
      trigger_source_select_r <= 4'h0;
    end else if (wr_smcfg) begin
      smc_r <= reg_wdata[`ATB_SMC_LO +: 3];
      ext_clock_mode1_enable_r <= reg_wdata[`ATB_EXT_CLOCK_MODE1_ENABLE_BIT];
      trigger_source_select_r <= reg_wdata[`ATB_TRIGGER_SOURCE_SELECT_LO +: 4];
    end
  end

  // preloads and the pairing register; counter and prescaler read the shadows, the repetition counter reloads from rep_pre_r on update
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      psc_pre_r <= `ATB_RST_PSC;
    end else if (wr_psc) begin
      psc_pre_r <= reg_wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      car_pre_r <= `ATB_RST_CAR;
    end else if (wr_car) begin
      car_pre_r <= reg_wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rep_pre_r <= {REP_W{1'b0}};
    end else if (wr_repetition_count) begin
      rep_pre_r <= reg_wdata[REP_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pair_mode_r <= 8'h00;
    end else if (wr_ctl2) begin
      pair_mode_r <= reg_wdata[7:0];
    end
  end

  // ==========================================
  // shadows, loaded only on an update event
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      psc_sh_r <= `ATB_RST_PSC;
      car_sh_r <= `ATB_RST_CAR;
      rep_sh_r <= {REP_W{1'b0}};
    end else if (upd) begin
      psc_sh_r <= psc_pre_r;
      car_sh_r <= car_pre_r;
      rep_sh_r <= rep_pre_r;
    end
  end

  // ==========================================
  // repetition counter
  // keeps counting while updates are disabled, so the rate holds on re-enable
  wire [REP_W-1:0] rep_step = rep_done ? rep_sh_r : rep_cnt_r - {{(REP_W-1){1'b0}}, 1'b1};
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rep_cnt_r <= {REP_W{1'b0}};
    end else if (upd) begin
      rep_cnt_r <= rep_pre_r;
    end else if (ovf || udf) begin
      rep_cnt_r <= rep_step;
    end
  end

  // ==========================================
  // prescaler and main counter
  // software update also restarts the prescaler count
  wire psc_clr = swu || (prescaler_input_clock && psc_wrap);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      psc_cnt_r <= 16'h0000;
    end else if (psc_clr) begin
      psc_cnt_r <= 16'h0000;
    end else if (prescaler_input_clock) begin
      psc_cnt_r <= psc_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================
  // update flag: hardware set wins over software clear
  wire wr_intf = reg_wr && (reg_addr == `ATB_OFS_INTF);
  wire clr_uif = wr_intf && !reg_wdata[0];
  wire set_uif = upd || (center && (ovf || udf) && !update_disable_r);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      uif_r <= 1'b0;
    end else if (set_uif) begin
      uif_r <= 1'b1;
    end else if (clr_uif) begin
      uif_r <= 1'b0;
    end
  end

  // ==========================================
  // channel pairing
  logic [3:0] main_o_nxt;
  logic [3:0] part_o_nxt;
  logic [3:0] part_cap_nxt;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      main_o_nxt[i] = main_channel_oc[i];
      case (atb_pkg::atb_pair_t'(pair_mode_r[2*i +: 2]))
        atb_pkg::ATB_PAIR_INDEP: begin
          part_o_nxt[i] = partner_channel_oc[i];
          part_cap_nxt[i] = 1'b1;
        end
        atb_pkg::ATB_PAIR_MIRROR: begin
          part_o_nxt[i] = main_channel_oc[i];
          part_cap_nxt[i] = 1'b0;
        end
        atb_pkg::ATB_PAIR_COMPL: begin
          part_o_nxt[i] = ~main_channel_oc[i];
          part_cap_nxt[i] = 1'b0;
        end
        default: begin
          part_o_nxt[i] = partner_channel_oc[i];
          part_cap_nxt[i] = 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // read mux
  wire [31:0] rd_ctl = {25'h0, cam_r, dir_r, 2'b00, update_disable_r, cen_r};
  wire [31:0] rd_smcfg = {24'h0, trigger_source_select_r, ext_clock_mode1_enable_r, smc_r};
  wire [31:0] rd_intf = {31'h0, uif_r};
  wire [31:0] rd_cnt = {16'h0, cnt_r};
  wire [31:0] rd_psc = {16'h0, psc_pre_r};
  wire [31:0] rd_car = {16'h0, car_pre_r};
  wire [31:0] rd_repetition_count = {{(32-REP_W){1'b0}}, rep_pre_r};
  wire [31:0] rd_ctl2 = {24'h0, pair_mode_r};
  // unmapped offsets read as zero
  wire [31:0] rd_mux =
    reg_addr == `ATB_OFS_CTL ? rd_ctl :
    reg_addr == `ATB_OFS_SMCFG ? rd_smcfg :
    reg_addr == `ATB_OFS_INTF ? rd_intf :
    reg_addr == `ATB_OFS_CNT ? rd_cnt :
    reg_addr == `ATB_OFS_PSC ? rd_psc :
    reg_addr == `ATB_OFS_CAR ? rd_car :
    reg_addr == `ATB_OFS_REPETITION_COUNT ? rd_repetition_count :
    reg_addr == `ATB_OFS_CTL2 ? rd_ctl2 : 32'h0000_0000;

  // ==========================================
  // registered outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      main_channel_out <= 4'h0;
      partner_channel_out <= 4'h0;
      partner_capture_en <= 4'h0;
    end else begin
      main_channel_out <= main_o_nxt;
      partner_channel_out <= part_o_nxt;
      partner_capture_en <= part_cap_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count_value <= 16'h0000;
      overflow_pulse <= 1'b0;
      underflow_pulse <= 1'b0;
      update_pulse <= 1'b0;
      count_dir <= 1'b0;
    end else begin
      count_value <= cnt_nxt;
      overflow_pulse <= ovf;
      underflow_pulse <= udf;
      update_pulse <= upd;
      count_dir <= dir_r;
    end
  end
endmodule : atb_time_base

// ---- dv/atb_time_base_assertions.sv ----
`timescale 1ns/100ps
`include "atb_cfg.svh"
// ==========================================
// port checks of the time base
module atb_time_base_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [3:0] main_channel_oc,
  input wire logic [3:0] partner_channel_oc,
  input wire logic [3:0] main_channel_out,
  input wire logic [3:0] partner_channel_out,
  input wire logic [3:0] partner_capture_en,
  input wire logic overflow_pulse,
  input wire logic underflow_pulse,
  input wire logic update_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic dis_r;
  logic [1:0] pair_r;
  logic [2:0] sw_r;
  logic [2:0] quiet_r;
  wire sw_wr = reg_wr && reg_addr == `ATB_OFS_SWEVG && reg_wdata[0];
  // snooped copies of control bits; the checker sees ports only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dis_r <= 1'b0;
      pair_r <= 2'b00;
      sw_r <= 3'd0;
      quiet_r <= 3'd0;
    end else begin
      if (reg_wr && reg_addr == `ATB_OFS_CTL) dis_r <= reg_wdata[`ATB_CTL_UPDATE_DISABLE];
      if (reg_wr && reg_addr == `ATB_OFS_CTL2) pair_r <= reg_wdata[1:0];
      sw_r <= sw_wr ? 3'd4 : (sw_r == 3'd0 ? 3'd0 : sw_r - 3'd1);
      quiet_r <= !dis_r ? 3'd0 : (quiet_r == 3'd4 ? 3'd4 : quiet_r + 3'd1);
    end
  end
  sequence sw_upd_s;
    sw_wr && !dis_r;
  endsequence
  sequence pair_s(logic [1:0] code);
    pair_r == code && $stable(pair_r) && $past(nrst);
  endsequence
  chk_sw_update: assert property (sw_upd_s |-> ##[1:3] update_pulse)
    else $error("software update gave no update pulse");
  chk_upd_cause: assert property (update_pulse |-> overflow_pulse || underflow_pulse || sw_r != 3'd0)
    else $error("update pulse without a cause");
  chk_upd_quiet: assert property (quiet_r == 3'd4 |-> !update_pulse)
    else $error("update pulse while updates disabled");
  chk_ovf_single: assert property (overflow_pulse |=> !overflow_pulse)
    else $error("overflow pulse longer than one cycle");
  chk_evt_excl: assert property (!(overflow_pulse && underflow_pulse))
    else $error("overflow and underflow together");
  chk_main_follow: assert property ($past(nrst) |-> main_channel_out == $past(main_channel_oc))
    else $error("main output does not follow compare level");
  chk_pair_indep: assert property (pair_s(2'b00) |-> partner_channel_out[0] == $past(partner_channel_oc[0]))
    else $error("independent partner output wrong");
  chk_pair_mirror: assert property (pair_s(2'b01) |-> partner_channel_out[0] == $past(main_channel_oc[0]))
    else $error("mirrored partner output wrong");
  chk_pair_compl: assert property (pair_s(2'b11) |-> partner_channel_out[0] != main_channel_out[0]
    && !partner_capture_en[0])
    else $error("complementary pair wrong");
endmodule : atb_time_base_assertions
bind atb_time_base atb_time_base_assertions atb_time_base_assertions_i (.*);

// ---- dv/atb_partner.sv ----
`timescale 1ns/100ps
// ==========================================
// far side: trigger lines, external trigger, channel pins
module atb_partner (
  input wire logic core_clk,
  output logic [3:0] internal_trigger_input,
  output logic external_trigger_input,
  output logic [3:0] main_channel_in,
  output logic [3:0] partner_channel_in
);
  // lines 0-3 triggers, 4-7 main pins, 8-11 partner pins, 12 external
  logic [12:0] pins = 13'h0;
  assign internal_trigger_input = pins[3:0];
  assign main_channel_in = pins[7:4];
  assign partner_channel_in = pins[11:8];
  assign external_trigger_input = pins[12];
  // w of 0 gives no pulse; any w of 1 or more is caught by the synchroniser
  task automatic burst(input int ln, input int n, input int w);
    repeat (n) begin
      pins[ln] <= 1'b1;
      repeat (w) @(posedge core_clk);
      pins[ln] <= 1'b0;
      repeat (w) @(posedge core_clk);
    end
  endtask : burst
endmodule : atb_partner

// ---- dv/atb_time_base_tb.sv ----
`timescale 1ns/100ps
`include "atb_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t got %h exp %h", $time, a, b); end end
module atb_time_base_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [3:0] main_channel_oc = 4'h0;
  logic [3:0] partner_channel_oc = 4'h0;
  logic [31:0] reg_rdata, rv;
  logic [3:0] internal_trigger_input, main_channel_in, partner_channel_in;
  logic [3:0] main_channel_out, partner_channel_out, partner_capture_en;
  logic external_trigger_input, overflow_pulse, underflow_pulse, update_pulse, count_dir;
  logic [15:0] count_value;
  wire [2:0] ev = {update_pulse, underflow_pulse, overflow_pulse};
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h9e61df04;
  int auto_reload_value, prescaler_value, rep, d, ex, ln;
  int srcs[9] = '{0, 1, 2, 3, 7, 4, 8, 12, 16};
  int pm[3] = '{0, 1, 3};
  atb_time_base atb_time_base_i (.*);
  atb_partner atb_partner_i (.*);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge core_clk);
    `CHK(rv, e)
  endtask : rd_chk
  // waits for event bit w: 0 overflow, 1 underflow, 2 update
  task automatic wp(input int w);
    for (int k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      #1;
      if (ev[w] === 1'b1) break;
    end
  endtask : wp
  task automatic gap(input int w, output int g);
    wp(w);
    g = cyc;
    wp(w);
    g = cyc - g;
  endtask : gap
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // ==========================================
    // reset values and unmapped space
    rd_chk(`ATB_OFS_CAR, 32'h0000ffff);
    rd_chk(`ATB_OFS_PSC, 32'h0);
    rd_chk(8'h3c, 32'h0);
    $display("test reset values done");
    // ==========================================
    // up, down, center with random reload, prescale, repetition
    for (int m = 0; m < 3; m++) begin
      auto_reload_value = 2 + ($random(seed) & 7);
      prescaler_value = $random(seed) & 3;
      rep = $random(seed) & 3;
      wr(`ATB_OFS_CTL, 32'(m << 4));
      wr(`ATB_OFS_CAR, auto_reload_value);
      wr(`ATB_OFS_PSC, prescaler_value);
      wr(`ATB_OFS_REPETITION_COUNT, rep);
      wr(`ATB_OFS_SWEVG, 32'h1);
      repeat (3) @(posedge core_clk);
      `CHK(count_value, (m == 1) ? 16'(auto_reload_value) : 16'h0)
      wr(`ATB_OFS_CTL, 32'(m << 4) | 32'h1);
      gap(m == 1, d);
      `CHK(d, (m == 2) ? 2 * auto_reload_value * (prescaler_value + 1) : (auto_reload_value + 1) * (prescaler_value + 1))
      gap(2, d);
      `CHK(d, (rep + 1) * ((m == 2) ? auto_reload_value : auto_reload_value + 1) * (prescaler_value + 1))
      if (m < 2) `CHK(count_dir, m[0])
    end
    rd_chk(`ATB_OFS_INTF, 32'h1);
    $display("test counting modes done");
    // ==========================================
    // preloads held back while updates are disabled
    wr(`ATB_OFS_CTL, 32'h3);
    wr(`ATB_OFS_INTF, 32'h0);
    wr(`ATB_OFS_PSC, prescaler_value + 1);
    wr(`ATB_OFS_CAR, auto_reload_value + 1);
    gap(0, d);
    `CHK(d, (auto_reload_value + 1) * (prescaler_value + 1))
    rd_chk(`ATB_OFS_INTF, 32'h0);
    wr(`ATB_OFS_CTL, 32'h1);
    wp(2);
    gap(0, d);
    `CHK(d, (auto_reload_value + 2) * (prescaler_value + 2))
    $display("test shadow loading done");
    // ==========================================
    // external clock sources, 16 stands for external mode 1
    wr(`ATB_OFS_PSC, 32'h0);
    wr(`ATB_OFS_CAR, 32'hffff);
    foreach (srcs[i]) begin
      wr(`ATB_OFS_CTL, 32'h0);
      wr(`ATB_OFS_SMCFG, (srcs[i] == 16) ? 32'h8 : 32'(srcs[i] << 4) | 32'h7);
      wr(`ATB_OFS_SWEVG, 32'h1);
      wr(`ATB_OFS_CTL, 32'h1);
      ln = (srcs[i] == 7 || srcs[i] == 16) ? 12 : (srcs[i] > 7 ? srcs[i] - 4 : srcs[i]);
      atb_partner_i.burst(ln, 3, 3 + i % 3);
      repeat (6) @(posedge core_clk);
      ex = (srcs[i] >= 4 && srcs[i] != 7 && srcs[i] != 16) ? 6 : 3;
      `CHK(count_value, 16'(ex))
    end
    $display("test clock sources done");
    // ==========================================
    // channel pairing with random compare levels
    foreach (pm[j]) begin
      wr(`ATB_OFS_CTL2, 32'({4{pm[j][1:0]}}));
      repeat (4) begin
        main_channel_oc <= 4'($random(seed));
        partner_channel_oc <= 4'($random(seed));
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(main_channel_out, main_channel_oc)
        `CHK(partner_channel_out, (pm[j] == 0) ? partner_channel_oc : (pm[j] == 1) ? main_channel_oc : ~main_channel_oc)
        `CHK(partner_capture_en, (pm[j] == 0) ? 4'hf : 4'h0)
      end
    end
    $display("test pairing done");
    stop_test();
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
endmodule : atb_time_base_tb
